// ===== common/fsl_defs.svh
// Constants for the fan speed loop with current limit
// Assumes inclusion by bare name from the package and the design
`ifndef FSL_DEFS_SVH
`define FSL_DEFS_SVH
`define FSL_SPEED_W      8
`define FSL_ERR_W        9
`define FSL_GAIN_W       4
`define FSL_ACC_FRAC     8
`define FSL_DUTY_MAX     8'hFF
`define FSL_ACC_RST      16'h0000
`define FSL_BIG_ERR      8'h20
`define FSL_DEAD_RST     8'h02
`define FSL_UPD_CYCLES   16'h0400
`endif

// ===== common/fsl_pkg.sv
// Types for the fan speed loop with current limit
// Assumes fsl_defs.svh on the include path
`include "fsl_defs.svh"
package fsl_pkg;
    typedef enum logic [1:0] {
        FSL_RUN   = 2'b00,
        FSL_TRIP  = 2'b01,
        FSL_LATCH = 2'b11
    } fsl_lim_t;
    typedef struct packed {
        logic [3:0] gain_low;
        logic [3:0] gain_std;
        logic [3:0] gain_high;
        logic       boost_en;
        logic       dead_en;
        logic [7:0] dead_band;
        logic       auto_restart;
        logic [7:0] big_err;
    } fsl_cfg_t;
endpackage

// ===== logic/fsl_speed_loop.sv
// Integral fan speed regulator with PWM winding drive and current limit
// Assumes speed samples and the overcurrent comparator come from outside the clock
`timescale 1ns/10ps
`include "fsl_defs.svh"
// Summary of operation
// R01: Overcurrent trip forces the winding output idle at once, in hardware.
// R02: With auto restart set, PWM resumes once comparator falls; else stays idle until limit_clear with comparator low.
// R03: Limit acts every PWM cycle in hardware with no software step.
// R04: Each comparator trip raises a one-cycle event pulse for software.
// R05: Accumulator adds error times gain each update; it sets the duty.
// R06: Speed far above target selects the reduced gain.
// R07: Speed close to target selects the standard gain.
// R08: Speed far below target selects the increased or the standard gain.
// R09: Active dead band zeroes errors smaller than the dead-band constant.
// R10: Dead band turns on only once measured speed equals the target.
// R11: Error leaving the dead band turns it off until target is reached.
// R12: No derivative term is used in the loop.
// R13: Measured speed is unsigned 8-bit, 255 meaning full speed.
// R14: Overflowed measurement sets invalid flag and the sample is not used.
// R15: Error is target minus measured, as a signed 9-bit value.
// R16: Accumulator saturates at zero and at full duty, never wraps.
module fsl_speed_loop
    import fsl_pkg::*;
#(
    parameter logic [15:0] UPD_CYCLES = `FSL_UPD_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic [`FSL_SPEED_W-1:0]   meas_speed,
    input  wire logic                      meas_ovf,
    input  wire logic [`FSL_SPEED_W-1:0]   set_speed,
    input  wire fsl_cfg_t                  cfg,
    input  wire logic                      ocp_trip,
    input  wire logic                      limit_clear,
    output logic                           winding_pwm,
    output logic                           ocp_event,
    output logic                           limited,
    output logic                           meas_invalid,
    output logic                           dead_active,
    output logic [`FSL_SPEED_W-1:0]        duty
);
    localparam int AW = `FSL_SPEED_W + `FSL_ACC_FRAC;
    logic [1:0]                 ocp_sync;
    logic                       ocp_prev;
    logic [`FSL_SPEED_W-1:0]    meas_s1;
    logic [`FSL_SPEED_W-1:0]    meas_s2;
    logic [1:0]                 ovf_sync;
    logic [`FSL_SPEED_W-1:0]    set_s1;
    logic [`FSL_SPEED_W-1:0]    set_s2;
    logic [`FSL_SPEED_W-1:0]    meas_s3;
    logic [`FSL_SPEED_W-1:0]    set_s3;
    logic [`FSL_SPEED_W-1:0]    meas_q;
    logic [`FSL_SPEED_W-1:0]    set_q;
    fsl_lim_t                   lim_state;
    logic [15:0]                upd_cnt;
    logic                       upd_tick;
    logic [`FSL_SPEED_W-1:0]    pwm_cnt;
    logic [AW-1:0]              acc;
    logic signed [`FSL_ERR_W-1:0] err;
    logic [`FSL_ERR_W-1:0]      err_mag;
    logic signed [`FSL_ERR_W-1:0] err_db;
    logic [`FSL_GAIN_W-1:0]     gain;
    logic signed [AW+1:0]       next_acc;
    logic                       run_ok;

    // Two flops on every asynchronous input, a third on the speed words; stages two and three are read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ocp_sync <= 2'h0;
            ovf_sync <= 2'h0;
            meas_s1  <= 8'h00;
            meas_s2  <= 8'h00;
            set_s1   <= 8'h00;
            set_s2   <= 8'h00;
            meas_s3  <= 8'h00;
            set_s3   <= 8'h00;
            ocp_prev <= 1'b0;
        end else begin
            ocp_sync <= {ocp_sync[0], ocp_trip};
            ovf_sync <= {ovf_sync[0], meas_ovf};
            meas_s1  <= meas_speed;
            meas_s2  <= meas_s1;
            set_s1   <= set_speed;
            set_s2   <= set_s1;
            meas_s3  <= meas_s2;
            set_s3   <= set_s2;
            ocp_prev <= ocp_sync[1];
        end
    end

    // A word is taken only once two synced copies agree, so bits caught
    // mid-change never reach the error path; costs two cycles of latency
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_q <= 8'h00;
            set_q  <= 8'h00;
        end else begin
            if (meas_s2 == meas_s3) begin
                meas_q <= meas_s2; // R13
            end
            if (set_s2 == set_s3) begin
                set_q <= set_s2;
            end
        end
    end

    // Trip event pulse for software
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ocp_event <= 1'b0;
        end else begin
            ocp_event <= ocp_sync[1] & ~ocp_prev; // R04
        end
    end

    // Limit state: the trip level wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lim_state <= FSL_RUN;
        end else begin
            case (lim_state)
                FSL_RUN: begin
                    if (ocp_sync[1]) begin
                        lim_state <= cfg.auto_restart ? FSL_TRIP : FSL_LATCH; // R01 R02
                    end
                end
                FSL_TRIP: begin
                    if (!ocp_sync[1]) begin
                        lim_state <= FSL_RUN; // R02 R03
                    end
                end
                FSL_LATCH: begin
                    if (limit_clear && !ocp_sync[1]) begin
                        lim_state <= FSL_RUN; // R02
                    end
                end
                default: begin
                    lim_state <= FSL_RUN;
                end
            endcase
        end
    end

    // Trip forces idle one cycle after the level reaches the second flop
    assign run_ok = (lim_state == FSL_RUN) && !ocp_sync[1]; // R01 R03

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            limited <= 1'b0;
        end else begin
            limited <= !run_ok;
        end
    end

    // Free running PWM; idle state is low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_cnt     <= 8'h00;
            winding_pwm <= 1'b0;
        end else begin
            pwm_cnt     <= pwm_cnt + 8'h01;
            winding_pwm <= run_ok && (pwm_cnt < duty); // R01 R03
        end
    end

    // Loop update tick
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            upd_cnt  <= 16'h0000;
            upd_tick <= 1'b0;
        end else begin
            upd_tick <= (upd_cnt == UPD_CYCLES - 16'h0001);
            upd_cnt  <= (upd_cnt == UPD_CYCLES - 16'h0001) ? 16'h0000 : upd_cnt + 16'h0001;
        end
    end

    // Invalid flag follows each overflowed sample
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_invalid <= 1'b0;
        end else if (upd_tick) begin
            meas_invalid <= ovf_sync[1]; // R14
        end
    end

    // Error and gain choice; no derivative path is kept on purpose
    always_comb begin
        err     = $signed({1'b0, set_q}) - $signed({1'b0, meas_q}); // R13 R15 R12
        err_mag = err[`FSL_ERR_W-1] ? 9'(-err) : 9'(err);
        if (err_mag > {1'b0, cfg.big_err} && err[`FSL_ERR_W-1]) begin
            gain = cfg.gain_low; // R06
        end else if (err_mag > {1'b0, cfg.big_err}) begin
            gain = cfg.boost_en ? cfg.gain_high : cfg.gain_std; // R08
        end else begin
            gain = cfg.gain_std; // R07
        end
        if (dead_active && err_mag < {1'b0, cfg.dead_band}) begin
            err_db = 9'sh000; // R09
        end else begin
            err_db = err;
        end
        next_acc = $signed({2'b00, acc}) + (AW+2)'(err_db) * (AW+2)'($signed({1'b0, gain})); // R05
    end

    // Dead band arms at the target and drops when the error escapes it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dead_active <= 1'b0;
        end else if (!cfg.dead_en) begin
            dead_active <= 1'b0;
        end else if (upd_tick && !ovf_sync[1]) begin
            if (err == 9'sh000) begin
                dead_active <= 1'b1; // R10
            end else if (err_mag >= {1'b0, cfg.dead_band}) begin
                dead_active <= 1'b0; // R11
            end
        end
    end

    // Accumulator with saturation; overflowed samples are skipped
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= `FSL_ACC_RST;
        end else if (upd_tick && !ovf_sync[1]) begin // R14
            if (next_acc < 0) begin
                acc <= '0; // R16
            end else if (next_acc > $signed({2'b00, `FSL_DUTY_MAX, 8'hFF})) begin
                acc <= {`FSL_DUTY_MAX, 8'hFF}; // R16
            end else begin
                acc <= AW'(next_acc); // R05
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            duty <= 8'h00;
        end else begin
            duty <= acc[AW-1:`FSL_ACC_FRAC]; // R05
        end
    end

    AST_TRIP_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
        ocp_sync[1] |=> !winding_pwm)
        else $error("PWM not idle after trip");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R02
        (lim_state == FSL_LATCH && !limit_clear) |=> lim_state == FSL_LATCH)
        else $error("Latched trip released");
    AST_AUTO_RESUME: assert property (@(posedge ref_clk) disable iff (!rst_b) // R03
        (lim_state == FSL_TRIP && !ocp_sync[1]) |=> lim_state == FSL_RUN)
        else $error("Auto restart missing");
    AST_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_b) // R04
        $rose(ocp_sync[1]) |=> ocp_event ##1 !ocp_event)
        else $error("Trip event wrong");
    AST_SAT: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
        (upd_tick && !ovf_sync[1] && next_acc < 0) |=> acc == '0)
        else $error("Accumulator not floored");
    AST_DB_ARM: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        (cfg.dead_en && upd_tick && !ovf_sync[1] && err == 9'sh000) |=> dead_active)
        else $error("Dead band not armed");
    AST_DB_DROP: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        (upd_tick && !ovf_sync[1] && err != 9'sh000 && err_mag >= {1'b0, cfg.dead_band})
        |=> !dead_active)
        else $error("Dead band not dropped");
    AST_DB_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b) // R09
        (dead_active && err_mag < {1'b0, cfg.dead_band}) |-> next_acc == $signed({2'b00, acc}))
        else $error("Small error passed");
    AST_OVF_SKIP: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        (upd_tick && ovf_sync[1]) |=> (meas_invalid && $stable(acc)))
        else $error("Overflow sample used");
    AST_GAIN_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b) // R06
        (err[`FSL_ERR_W-1] && err_mag > {1'b0, cfg.big_err}) |-> gain == cfg.gain_low)
        else $error("Reduced gain not chosen");
    AST_GAIN_STD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R07
        (err_mag <= {1'b0, cfg.big_err}) |-> gain == cfg.gain_std)
        else $error("Standard gain not chosen");
    AST_GAIN_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b) // R08
        (!err[`FSL_ERR_W-1] && err_mag > {1'b0, cfg.big_err} && cfg.boost_en)
        |-> gain == cfg.gain_high)
        else $error("Increased gain not chosen");
    AST_LIMIT_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
        limited |-> !winding_pwm)
        else $error("PWM driven while limited");
    AST_LATCH_ENTRY: assert property (@(posedge ref_clk) disable iff (!rst_b) // R02
        (lim_state == FSL_RUN && ocp_sync[1] && !cfg.auto_restart) |=> lim_state == FSL_LATCH)
        else $error("Trip not latched");
    AST_CLEAR_REFUSED: assert property (@(posedge ref_clk) disable iff (!rst_b) // R02
        (lim_state == FSL_LATCH && ocp_sync[1]) |=> lim_state == FSL_LATCH)
        else $error("Clear accepted during trip");
    AST_CLEAR_OK: assert property (@(posedge ref_clk) disable iff (!rst_b) // R02
        (lim_state == FSL_LATCH && limit_clear && !ocp_sync[1]) |=> lim_state == FSL_RUN)
        else $error("Clear not accepted");
    AST_EVENT_SRC: assert property (@(posedge ref_clk) disable iff (!rst_b) // R04
        ocp_event |-> ($past(ocp_sync[1]) && !$past(ocp_prev)))
        else $error("Event without trip edge");
    AST_CAP_TOP: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
        (upd_tick && !ovf_sync[1] && next_acc > $signed({2'b00, `FSL_DUTY_MAX, 8'hFF}))
        |=> acc == {`FSL_DUTY_MAX, 8'hFF})
        else $error("Accumulator not capped");
    AST_ACC_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
        (upd_tick && !ovf_sync[1] && next_acc >= 0
         && next_acc <= $signed({2'b00, `FSL_DUTY_MAX, 8'hFF}))
        |=> $signed({2'b00, acc}) == $past(next_acc))
        else $error("Accumulator step wrong");
    AST_ACC_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
        !upd_tick |=> $stable(acc))
        else $error("Accumulator moved between updates");
    AST_DUTY: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
        1'b1 |=> duty == $past(acc[AW-1:`FSL_ACC_FRAC]))
        else $error("Duty not taken from accumulator");
    AST_INVALID: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        upd_tick |=> meas_invalid == $past(ovf_sync[1]))
        else $error("Invalid flag wrong");
endmodule

// ===== test/fsl_fan_model.sv
// Behavioural model of the winding transistors, the sense resistor and the current comparator
// Assumes one clock shared with the speed loop and an overload request from the bench
`timescale 1ns/10ps
module fsl_fan_model #(
    parameter int TRIP_LVL = 8
) (
    input  wire logic ref_clk,
    input  wire logic winding_pwm,
    input  wire logic overload,
    output logic      ocp_trip
);
    int cur = 0;
    // Current builds while driven into an overload and decays once the winding is idle
    initial begin
        ocp_trip = 1'b0;
        forever begin
            @(posedge ref_clk);
            #1;
            if (overload && winding_pwm)
                cur++;
            else if (cur > 0)
                cur--;
            // Hysteresis keeps the comparator high until the current has fully decayed
            if (cur >= TRIP_LVL)
                ocp_trip = 1'b1;
            else if (cur == 0)
                ocp_trip = 1'b0;
        end
    end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the fan speed loop, with an integer model of the integrator
// Assumes fsl_fan_model as far side and a short update interval of four cycles
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
    import fsl_pkg::*;
    logic       ref_clk, rst_b, meas_ovf, ocp_trip, limit_clear, overload;
    logic [7:0] meas_speed, set_speed, duty;
    logic       winding_pwm, ocp_event, limited, meas_invalid, dead_active;
    logic [3:0] h = 4'h0;
    fsl_cfg_t   cfg;
    int         error_cnt = 0, num_checks = 0, rise_cnt = 0, ev_cnt = 0;
    int         acc = 0, dz = 0, qs = 255, qm = 0, qo = 0;
    int         pc = 0, pre = 0;
    logic [7:0] dq = 8'h00;

    fsl_speed_loop #(.UPD_CYCLES(16'h0004)) fsl_speed_loop_inst (.ref_clk(ref_clk),
        .rst_b(rst_b), .meas_speed(meas_speed), .meas_ovf(meas_ovf), .set_speed(set_speed),
        .cfg(cfg), .ocp_trip(ocp_trip), .limit_clear(limit_clear), .winding_pwm(winding_pwm),
        .ocp_event(ocp_event), .limited(limited), .meas_invalid(meas_invalid),
        .dead_active(dead_active), .duty(duty));
    fsl_fan_model fsl_fan_model_inst (.ref_clk(ref_clk), .winding_pwm(winding_pwm),
        .overload(overload), .ocp_trip(ocp_trip));

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // One loop update, using the speeds that were applied one update earlier
    task automatic model();
        int e, g, b, big;
        b = cfg.dead_band;
        big = cfg.big_err;
        if (!qo) begin
            e = qs - qm;
            g = (e < -big) ? cfg.gain_low : (e > big) ?
                (cfg.boost_en ? cfg.gain_high : cfg.gain_std) : cfg.gain_std;
            if (!cfg.dead_en)
                dz = 0;
            else if (e == 0)
                dz = 1;
            else if (e >= b || -e >= b)
                dz = 0;
            if (dz == 1 && e < b && -e < b)
                e = 0;
            acc = acc + e * g;
            if (acc < 0)
                acc = 0;
            if (acc > 65535)
                acc = 65535;
        end
        `CHK(duty, 8'(acc >> 8))
        `CHK(meas_invalid, 1'(qo))
        `CHK(dead_active, 1'(dz))
    endtask

    // Inputs change well clear of the sampling tick, so each update is unambiguous
    task automatic step(input int s, input int m, input int o, input int n);
        repeat (n) begin
            cyc(1);
            set_speed = 8'(s);
            meas_speed = 8'(m);
            meas_ovf = 1'(o);
            cyc(3);
            model();
            qs = s;
            qm = m;
            qo = o;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        h = {h[2:0], ocp_trip};
        if (h[0] && !h[1])
            rise_cnt++;
        // PWM counter of the bench: one period is 256 cycles from reset release
        pre = pc;
        dq = duty;
        pc = (rst_b === 1'b1) ? (pc + 1) % 256 : 0;
        #1;
        if (limited === 1'b0) `CHK(winding_pwm, 1'(pre < dq))
        if (ocp_event === 1'b1)
            ev_cnt++;
        if (limited === 1'b1) `CHK(winding_pwm, 1'b0)
        if (h[2] && !h[3]) `CHK(ocp_event, 1'b1)
        if (h[2] && !h[3]) `CHK(winding_pwm, 1'b0)
    end

    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        void'($urandom(1));
        rst_b = 1'b0;
        meas_ovf = 1'b0;
        limit_clear = 1'b0;
        overload = 1'b0;
        set_speed = 8'hFF;
        meas_speed = 8'h00;
        cfg = '{gain_low:4'h3, gain_std:4'h5, gain_high:4'h9, boost_en:1'b1, dead_en:1'b0,
                dead_band:8'h10, auto_restart:1'b1, big_err:8'h20};
        cyc(4);
        rst_b = 1'b1;
        // The first duty change marks the update phase for the rest of the run
        for (int i = 0; i < 60 && duty === 8'h00; i++)
            cyc(1);
        model();
        step(8'hFF, 8'h00, 0, 30);
        step(8'h00, 8'hFF, 0, 90);
        cfg.boost_en = 1'b0;
        step(8'h60, 8'h10, 0, 20);
        cfg.dead_en = 1'b1;
        step(8'h50, 8'h50, 0, 3);
        step(8'h5C, 8'h50, 0, 8);
        step(8'h50, 8'h64, 0, 4);
        step(8'h5A, 8'h50, 0, 8);
        step(8'h5A, 8'h50, 1, 3);
        repeat (40)
            step(120 + $urandom_range(8), 120 + $urandom_range(8), $urandom_range(7) == 0, 1);
        cfg.boost_en = 1'b1;
        step(8'hFF, 8'h00, 0, 30);
        overload = 1'b1;
        cyc(2000);
        overload = 1'b0;
        cyc(100);
        `CHK(ev_cnt > 3, 1'b1)
        cfg.auto_restart = 1'b0;
        overload = 1'b1;
        wait (ocp_trip === 1'b1);
        cyc(1);
        limit_clear = 1'b1;
        cyc(3);
        `CHK(limited, 1'b1)
        limit_clear = 1'b0;
        cyc(100);
        `CHK(limited, 1'b1)
        overload = 1'b0;
        limit_clear = 1'b1;
        cyc(10);
        `CHK(limited, 1'b0)
        limit_clear = 1'b0;
        cyc(10);
        `CHK(ev_cnt, rise_cnt)
        give_verdict();
    end
endmodule
